/* File: src/spl_pkg.sv */
// Constants for the serial programming latches of the synthesizer.
// Assumes a single 20 MHz system clock samples every pin.
`default_nettype none
package spl_pkg;
  // --------------------------------------------------------------
  // Word and latch geometry
  // --------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int NUM_LATCH = 8;
  localparam int SEL_W = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [2:0] SEL_DIVIDE = 3'h0;
  localparam logic [2:0] SEL_FINE = 3'h1;
  localparam logic [2:0] SEL_REFDIV = 3'h2;
  localparam logic [2:0] SEL_FUNCTION = 3'h3;
  localparam logic [2:0] SEL_CLKDIV = 3'h4;
  localparam logic [2:0] SEL_DEVIATION = 3'h5;
  localparam logic [2:0] SEL_STEP = 3'h6;
  localparam logic [2:0] SEL_DELAY = 3'h7;
  // --------------------------------------------------------------
  // Divide-ratio word fields
  // --------------------------------------------------------------
  localparam int RAMP_BIT = 31;
  localparam int MON_MSB = 30;
  localparam int MON_LSB = 27;
  localparam int WHOLE_MSB = 26;
  localparam int WHOLE_LSB = 15;
  localparam int FHI_MSB = 14;
  localparam int FHI_LSB = 3;
  // --------------------------------------------------------------
  // Fine-ratio and phase word fields
  // --------------------------------------------------------------
  localparam int RSV1_MSB = 31;
  localparam int RSV1_LSB = 29;
  localparam int PHADJ_BIT = 28;
  localparam int FLO_MSB = 27;
  localparam int FLO_LSB = 15;
  localparam int PHASE_MSB = 14;
  localparam int PHASE_LSB = 3;
  // --------------------------------------------------------------
  // Reference divider word fields
  // --------------------------------------------------------------
  localparam int SLIP_BIT = 28;
  localparam int PUMP_MSB = 27;
  localparam int PUMP_LSB = 24;
  localparam int PRESC_BIT = 22;
  localparam int HALVER_BIT = 21;
  localparam int DOUBLER_BIT = 20;
  localparam int RDIV_MSB = 19;
  localparam int RDIV_LSB = 15;
  localparam int STEP_MSB = 14;
  localparam int STEP_LSB = 3;
  // --------------------------------------------------------------
  // Field widths
  // --------------------------------------------------------------
  localparam int FINE_W = 25;
  localparam int PHASE_W = 12;
  localparam int PUMP_W = 4;
  localparam int RDIV_W = 5;
  localparam int STEP_W = 12;
  localparam int MON_W = 4;
  localparam int SYNC_W = 4;
  // --------------------------------------------------------------
  // Monitor output select codes
  // --------------------------------------------------------------
  localparam logic [3:0] MON_LOW = 4'h0;
  localparam logic [3:0] MON_HIGH = 4'h1;
  localparam logic [3:0] MON_REF_OUT = 4'h2;
  localparam logic [3:0] MON_SERIAL = 4'h3;
  localparam logic [3:0] MON_RAMP = 4'h4;
  localparam logic [3:0] MON_PHADJ = 4'h5;
endpackage
`default_nettype wire

/* File: src/pin_sync2.sv */
// Two flip-flop synchroniser for the serial and reference pins.
// Assumes the pins are asynchronous to i_clk.
`default_nettype none
module pin_sync2 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [spl_pkg::SYNC_W-1:0] i_pins,
  output logic [spl_pkg::SYNC_W-1:0] o_pins
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [spl_pkg::SYNC_W-1:0] meta;
    logic [spl_pkg::SYNC_W-1:0] stable;
  } sync_s;
  sync_s s_q;
  sync_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = i_pins;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pins = s_q.stable;
endmodule // pin_sync2
`default_nettype wire

/* File: src/ref_counter.sv */
// Programmable reference counter, ratio 1 to 32, with halver output.
// Assumes i_edge is a one-cycle pulse per active reference edge.
`default_nettype none
module ref_counter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_edge,
  input wire logic [spl_pkg::RDIV_W-1:0] i_ratio,
  output logic o_tick,
  output logic o_half
);
  typedef struct packed {
    logic [spl_pkg::RDIV_W-1:0] count;
    logic tick;
    logic half;
  } cnt_s;
  cnt_s s_q;
  cnt_s s_d;
  logic [spl_pkg::RDIV_W-1:0] last;

  // --------------------------------------------------------------
  // Count; code zero wraps to a ratio of 32
  // --------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    last = i_ratio - 5'h01;
    s_d.tick = 1'b0;
    if (i_edge) begin
      if (s_q.count >= last) begin // [RULE_10]
        s_d.count = 5'h00;
        s_d.tick = 1'b1;
        s_d.half = ~s_q.half;
      end else begin
        s_d.count = s_q.count + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;
  assign o_half = s_q.half;

  property p_ref_period;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_edge && (s_q.count == last) |=> o_tick && (s_q.count == 5'h00);
  endproperty
  a_ref_period: assert property (p_ref_period) // [RULE_10]
    else $error("reference counter missed its terminal count");
endmodule // ref_counter
`default_nettype wire

/* File: src/synth_serial_program_latches.sv */
// Serial programming front end: shift register and eight latches.
// Assumes serial pins and reference arrive asynchronously to i_clk.
//
// Operation
// [RULE_01] Shift data in on each serial clock rise
// [RULE_02] Words arrive MSB first, first bit is 31
// [RULE_03] Load strobe rise copies word to one latch
// [RULE_04] Three low word bits pick the latch
// [RULE_05] Select bits decode as plain binary index
// [RULE_06] Buffered settings apply on next divide-ratio write
// [RULE_07] Fine low bits wait for divide-ratio write
// [RULE_08] Fine numerator: 12 high, 13 low bits
// [RULE_09] Hold whole ratio, fine numerator, reference divider
// [RULE_10] Reference counter divides by 1 to 32
// [RULE_11] Monitor select sits in bits 30 to 27
// [RULE_12] Fine-ratio word layout: adjust, low fine, phase
// [RULE_13] Reference word layout: slip, pump, dividers
// [RULE_14] Phase offset applies after next divide-ratio write
// [RULE_15] Bit 31 of divide word enables ramp
// [RULE_16] Host keeps strobe low while shifting
// [RULE_17] Host writes zero into reserved bits
`default_nettype none
module synth_serial_program_latches (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  input wire logic i_ref_in,
  output logic o_ramp_enable,
  output logic [spl_pkg::MON_W-1:0] o_monitor_select,
  output logic [11:0] o_whole_value,
  output logic [spl_pkg::FINE_W-1:0] o_fine_divide_numerator,
  output logic [spl_pkg::PHASE_W-1:0] o_phase_value,
  output logic o_phase_adjust_enable,
  output logic o_slip_reduction_enable,
  output logic [spl_pkg::PUMP_W-1:0] o_pump_current,
  output logic o_prescaler_select,
  output logic o_reference_halver,
  output logic o_reference_doubler,
  output logic [spl_pkg::RDIV_W-1:0] o_ref_div_value,
  output logic [spl_pkg::STEP_W-1:0] o_step_time_divider,
  output logic [31:0] o_function_word,
  output logic [31:0] o_clock_divider_word,
  output logic [31:0] o_deviation_word,
  output logic [31:0] o_step_word,
  output logic [31:0] o_delay_word,
  output logic o_freq_update,
  output logic o_phase_update,
  output logic o_ref_divided,
  output logic o_monitor_output_pin
);
  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [spl_pkg::SYNC_W-1:0] pins_s;
  logic sclk_s;
  logic data_s;
  logic strobe_s;
  logic ref_s;

  pin_sync2 u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_pins({i_ref_in, i_load_strobe, i_serial_data, i_serial_clk}),
    .o_pins(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign data_s = pins_s[1];
  assign strobe_s = pins_s[2];
  assign ref_s = pins_s[3];

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [31:0] shift;
    logic sclk_prev;
    logic strobe_prev;
    logic ref_prev;
    logic [spl_pkg::NUM_LATCH-1:0][31:0] latch;
    logic [spl_pkg::FINE_W-1:0] act_fine;
    logic [spl_pkg::PHASE_W-1:0] act_phase;
    logic [spl_pkg::PUMP_W-1:0] act_pump;
    logic act_halver;
    logic act_doubler;
    logic [spl_pkg::RDIV_W-1:0] act_rdiv;
    logic [spl_pkg::STEP_W-1:0] act_step;
    logic freq_upd;
    logic phase_upd;
    logic ref_out;
    logic mon;
  } top_s;
  top_s s_q;
  top_s s_d;

  // --------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------
  function automatic logic [2:0] latch_index(input logic [31:0] word);
    latch_index = word[spl_pkg::SEL_MSB:spl_pkg::SEL_LSB];
  endfunction

  function automatic logic monitor_pick(
    input logic [3:0] code,
    input logic ref_out,
    input logic serial,
    input logic ramp,
    input logic phadj
  );
    if (code == spl_pkg::MON_HIGH) begin
      monitor_pick = 1'b1;
    end else if (code == spl_pkg::MON_REF_OUT) begin
      monitor_pick = ref_out;
    end else if (code == spl_pkg::MON_SERIAL) begin
      monitor_pick = serial;
    end else if (code == spl_pkg::MON_RAMP) begin
      monitor_pick = ramp;
    end else if (code == spl_pkg::MON_PHADJ) begin
      monitor_pick = phadj;
    end else begin
      monitor_pick = 1'b0;
    end
  endfunction

  // --------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------
  logic sclk_rise;
  logic strobe_rise;
  logic ref_edge;
  logic [2:0] sel;
  logic ref_tick;
  logic ref_half;

  assign sclk_rise = sclk_s & ~s_q.sclk_prev;
  assign strobe_rise = strobe_s & ~s_q.strobe_prev;
  assign sel = latch_index(s_q.shift);
  assign ref_edge = s_q.act_doubler ? (ref_s ^ s_q.ref_prev) : (~ref_s & s_q.ref_prev);

  ref_counter u_ref (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_edge(ref_edge),
    .i_ratio(s_q.act_rdiv),
    .o_tick(ref_tick),
    .o_half(ref_half)
  );

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sclk_prev = sclk_s;
    s_d.strobe_prev = strobe_s;
    s_d.ref_prev = ref_s;
    s_d.freq_upd = 1'b0;
    s_d.phase_upd = 1'b0;
    if (sclk_rise) begin
      s_d.shift = {s_q.shift[30:0], data_s}; // [RULE_01] [RULE_02]
    end
    if (strobe_rise) begin
      s_d.latch[sel] = s_q.shift; // [RULE_03] [RULE_04] [RULE_05]
      if (sel == spl_pkg::SEL_DIVIDE) begin
        s_d.act_fine = {s_q.shift[spl_pkg::FHI_MSB:spl_pkg::FHI_LSB],
                        s_q.latch[1][spl_pkg::FLO_MSB:spl_pkg::FLO_LSB]}; // [RULE_07] [RULE_08]
        s_d.act_phase = s_q.latch[1][spl_pkg::PHASE_MSB:spl_pkg::PHASE_LSB]; // [RULE_14]
        s_d.act_pump = s_q.latch[2][spl_pkg::PUMP_MSB:spl_pkg::PUMP_LSB]; // [RULE_06]
        s_d.act_halver = s_q.latch[2][spl_pkg::HALVER_BIT]; // [RULE_06]
        s_d.act_doubler = s_q.latch[2][spl_pkg::DOUBLER_BIT]; // [RULE_06]
        s_d.act_rdiv = s_q.latch[2][spl_pkg::RDIV_MSB:spl_pkg::RDIV_LSB]; // [RULE_06] [RULE_09]
        s_d.act_step = s_q.latch[2][spl_pkg::STEP_MSB:spl_pkg::STEP_LSB]; // [RULE_06] [RULE_13]
        s_d.freq_upd = 1'b1; // [RULE_07]
        s_d.phase_upd = s_q.latch[1][spl_pkg::PHADJ_BIT]; // [RULE_14] [RULE_12]
      end
    end
    s_d.ref_out = s_q.act_halver ? ref_half : ref_tick;
    s_d.mon = monitor_pick(s_q.latch[0][spl_pkg::MON_MSB:spl_pkg::MON_LSB], // [RULE_11]
                           s_q.ref_out, data_s,
                           s_q.latch[0][spl_pkg::RAMP_BIT],
                           s_q.latch[1][spl_pkg::PHADJ_BIT]);
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign o_ramp_enable = s_q.latch[0][spl_pkg::RAMP_BIT]; // [RULE_15]
  assign o_monitor_select = s_q.latch[0][spl_pkg::MON_MSB:spl_pkg::MON_LSB]; // [RULE_11]
  assign o_whole_value = s_q.latch[0][spl_pkg::WHOLE_MSB:spl_pkg::WHOLE_LSB]; // [RULE_09]
  assign o_fine_divide_numerator = s_q.act_fine;
  assign o_phase_value = s_q.act_phase;
  assign o_phase_adjust_enable = s_q.latch[1][spl_pkg::PHADJ_BIT]; // [RULE_12]
  assign o_slip_reduction_enable = s_q.latch[2][spl_pkg::SLIP_BIT]; // [RULE_13]
  assign o_pump_current = s_q.act_pump;
  assign o_prescaler_select = s_q.latch[2][spl_pkg::PRESC_BIT]; // [RULE_13]
  assign o_reference_halver = s_q.act_halver;
  assign o_reference_doubler = s_q.act_doubler;
  assign o_ref_div_value = s_q.act_rdiv;
  assign o_step_time_divider = s_q.act_step;
  assign o_function_word = s_q.latch[3];
  assign o_clock_divider_word = s_q.latch[4];
  assign o_deviation_word = s_q.latch[5];
  assign o_step_word = s_q.latch[6];
  assign o_delay_word = s_q.latch[7];
  assign o_freq_update = s_q.freq_upd;
  assign o_phase_update = s_q.phase_upd;
  assign o_ref_divided = s_q.ref_out;
  assign o_monitor_output_pin = s_q.mon;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_shift_in;
    @(posedge i_clk) disable iff (!rst_n_q)
    sclk_rise |=> s_q.shift[0] == $past(data_s);
  endproperty
  a_shift_in: assert property (p_shift_in) // [RULE_01]
    else $error("serial bit not taken on clock rise");

  property p_msb_first;
    @(posedge i_clk) disable iff (!rst_n_q)
    sclk_rise |=> s_q.shift[31:1] == $past(s_q.shift[30:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) // [RULE_02]
    else $error("shift register did not move toward bit 31");

  property p_shift_hold;
    @(posedge i_clk) disable iff (!rst_n_q)
    !sclk_rise |=> $stable(s_q.shift);
  endproperty
  a_shift_hold: assert property (p_shift_hold) // [RULE_01]
    else $error("shift register moved without a clock rise");

  property p_load;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise |=> s_q.latch[$past(sel)] == $past(s_q.shift);
  endproperty
  a_load: assert property (p_load) // [RULE_03]
    else $error("selected latch did not take the word");

  property p_only_one;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise && (sel != spl_pkg::SEL_DIVIDE) |=> $stable(s_q.latch[0]);
  endproperty
  a_only_one: assert property (p_only_one) // [RULE_05]
    else $error("divide-ratio latch written by another select code");

  property p_sel_map;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise && (s_q.shift[2:0] == spl_pkg::SEL_REFDIV) |=> $stable(s_q.latch[1]);
  endproperty
  a_sel_map: assert property (p_sel_map) // [RULE_04]
    else $error("select bits decoded to the wrong latch");

  property p_buffered;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise && (sel != spl_pkg::SEL_DIVIDE) |=>
      $stable(s_q.act_rdiv) && $stable(s_q.act_pump) && !o_freq_update;
  endproperty
  a_buffered: assert property (p_buffered) // [RULE_06]
    else $error("buffered setting applied without divide-ratio write");

  property p_fine_join;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise && (sel == spl_pkg::SEL_DIVIDE) |=> o_freq_update &&
      o_fine_divide_numerator == {$past(s_q.shift[14:3]), $past(s_q.latch[1][27:15])};
  endproperty
  a_fine_join: assert property (p_fine_join) // [RULE_08]
    else $error("fine numerator not joined from both words");

  property p_phase;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise && (sel == spl_pkg::SEL_DIVIDE) |=>
      o_phase_value == $past(s_q.latch[1][14:3]) && o_phase_update == $past(s_q.latch[1][28]);
  endproperty
  a_phase: assert property (p_phase) // [RULE_14]
    else $error("phase value not applied on divide-ratio write");

  property p_mon_ramp;
    @(posedge i_clk) disable iff (!rst_n_q)
    strobe_rise && (sel == spl_pkg::SEL_DIVIDE) |=>
      o_ramp_enable == $past(s_q.shift[31]) && o_monitor_select == $past(s_q.shift[30:27]);
  endproperty
  a_mon_ramp: assert property (p_mon_ramp) // [RULE_15]
    else $error("ramp enable or monitor select wrong after load");

  property p_update_pulse;
    @(posedge i_clk) disable iff (!rst_n_q)
    o_freq_update |=> !o_freq_update;
  endproperty
  a_update_pulse: assert property (p_update_pulse) // [RULE_07]
    else $error("frequency update pulse longer than one cycle");
endmodule // synth_serial_program_latches
`default_nettype wire

/* File: verification/spl_host_model.sv */
// Host-side model of the three-wire serial programming link.
// Assumes the bench calls send_word and that i_clk runs at 20 MHz.
`default_nettype none
module spl_host_model (
  input wire logic i_clk,
  output var logic o_serial_clk,
  output var logic o_serial_data,
  output var logic o_load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Link idles with clock and strobe low
  initial begin
    o_serial_clk = 1'b0;
    o_serial_data = 1'b0;
    o_load_strobe = 1'b0;
  end

  // Half of the 400 ns link period
  task automatic half_period();
    repeat (4) @(negedge i_clk);
  endtask

  // One whole word, then the load strobe
  task automatic send_word(input logic [31:0] word);
    for (int i = 31; i >= 0; i--) begin
      o_serial_data = word[i];
      half_period();
      o_serial_clk = 1'b1;
      half_period();
      o_serial_clk = 1'b0;
    end
    // Released data line shows the inverse of its last value
    o_serial_data = ~word[0];
    half_period();
    o_load_strobe = 1'b1;
    half_period();
    o_load_strobe = 1'b0;
    repeat (8) @(negedge i_clk);
  endtask
endmodule // spl_host_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the serial programming latches.
// Assumes the host model drives the link and the bench drives the reference.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TIMEOUT_CYCLES = 20000;
  logic i_clk, i_rst_n, i_ref_in, i_serial_clk, i_serial_data, i_load_strobe;
  logic o_ramp_enable, o_phase_adjust_enable, o_slip_reduction_enable, o_prescaler_select;
  logic o_reference_halver, o_reference_doubler, o_freq_update, o_phase_update;
  logic o_ref_divided, o_monitor_output_pin;
  logic [3:0] o_monitor_select, o_pump_current;
  logic [11:0] o_whole_value, o_phase_value, o_step_time_divider;
  logic [24:0] o_fine_divide_numerator;
  logic [4:0] o_ref_div_value;
  logic [31:0] o_function_word, o_clock_divider_word, o_deviation_word, o_step_word, o_delay_word;
  logic [31:0] exp_raw [3:7] = '{default: 32'h0};
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int freq_pulses = 0;
  int phase_pulses = 0;
  int ref_pulses = 0;
  int mon_pulses = 0;
  logic ref_last = 1'b0;
  logic mon_last = 1'b0;

  synth_serial_program_latches dut_u (
    .i_clk, .i_rst_n, .i_serial_clk, .i_serial_data, .i_load_strobe, .i_ref_in,
    .o_ramp_enable, .o_monitor_select, .o_whole_value, .o_fine_divide_numerator,
    .o_phase_value, .o_phase_adjust_enable, .o_slip_reduction_enable, .o_pump_current,
    .o_prescaler_select, .o_reference_halver, .o_reference_doubler, .o_ref_div_value,
    .o_step_time_divider, .o_function_word, .o_clock_divider_word, .o_deviation_word,
    .o_step_word, .o_delay_word, .o_freq_update, .o_phase_update, .o_ref_divided,
    .o_monitor_output_pin
  );

  spl_host_model host_u (
    .i_clk,
    .o_serial_clk(i_serial_clk),
    .o_serial_data(i_serial_data),
    .o_load_strobe(i_load_strobe)
  );

  // --------------------------------------------------------------
  // Clock, pulse counters, timeout
  // --------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (o_freq_update === 1'b1) freq_pulses++;
    if (o_phase_update === 1'b1) phase_pulses++;
    if (o_ref_divided === 1'b1 && ref_last === 1'b0) ref_pulses++;
    if (o_monitor_output_pin === 1'b1 && mon_last === 1'b0) mon_pulses++;
    ref_last = o_ref_divided;
    mon_last = o_monitor_output_pin;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      bad_count++;
      complete_run();
    end
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] div_word(input logic ramp, input logic [3:0] mon,
                                           input logic [11:0] whole, input logic [11:0] fhi);
    return {ramp, mon, whole, fhi, spl_pkg::SEL_DIVIDE};
  endfunction

  function automatic logic [31:0] fine_word(input logic padj, input logic [12:0] flo,
                                            input logic [11:0] phase);
    return {3'h0, padj, flo, phase, spl_pkg::SEL_FINE};
  endfunction

  // Slip on, pump 9, prescaler on, step C3A, halver and doubler from hd
  function automatic logic [31:0] ref_word(input logic [4:0] rdiv, input logic [1:0] hd);
    return {3'h0, 1'b1, 4'h9, 1'b0, 1'b1, hd, rdiv, 12'hC3A, spl_pkg::SEL_REFDIV};
  endfunction

  function automatic logic [31:0] raw_out(input int k);
    case (k)
      3: return o_function_word;
      4: return o_clock_divider_word;
      5: return o_deviation_word;
      6: return o_step_word;
      default: return o_delay_word;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic check_reset();
    check_val(32'({o_ramp_enable, o_monitor_select, o_whole_value, o_ref_div_value}),
              32'h0);
    check_val(32'(o_fine_divide_numerator), 32'h0);
    check_val(32'({o_phase_value, o_step_time_divider, o_pump_current}), 32'h0);
  endtask

  task automatic scn_raw_latches();
    logic [31:0] w;
    for (int k = 3; k <= 7; k++) begin
      w = {4'hA, 4'(k), 16'h5C3E, 5'h12, 3'(k)};
      exp_raw[k] = w;
      host_u.send_word(w);
      for (int j = 3; j <= 7; j++) begin
        check_val(raw_out(j), exp_raw[j]);
      end
    end
  endtask

  task automatic scn_double_buffer();
    host_u.send_word(fine_word(1'b1, 13'h1ABC, 12'h5A5));
    host_u.send_word(ref_word(5'h03, 2'h3));
    check_val(32'({o_phase_adjust_enable, o_slip_reduction_enable, o_prescaler_select}),
              32'h7);
    check_val(32'(o_fine_divide_numerator), 32'h0);
    check_val(32'({o_phase_value, o_pump_current, o_ref_div_value, o_reference_halver,
                   o_reference_doubler}), 32'h0);
    check_val({o_step_time_divider, 20'(freq_pulses)}, 32'h0);
    host_u.send_word(div_word(1'b1, 4'h1, 12'hABC, 12'h123));
    check_val(32'(o_fine_divide_numerator), 32'({12'h123, 13'h1ABC}));
    check_val(32'(o_phase_value), 32'h5A5);
    check_val(32'({o_pump_current, o_reference_halver, o_reference_doubler, o_ref_div_value,
                   o_step_time_divider}), 32'h4E3C3A);
    check_val(32'({o_ramp_enable, o_monitor_select, o_whole_value}), 32'h11ABC);
    check_val(32'(freq_pulses), 32'h1);
    check_val(32'(phase_pulses), 32'h1);
  endtask

  // Monitor shows the reference output; rises of both are counted
  task automatic scn_ref_counter(input logic [4:0] code, input logic [1:0] hd,
                                 input int edges, input int rises);
    int start;
    int mstart;
    host_u.send_word(ref_word(code, hd));
    host_u.send_word(div_word(1'b0, 4'h2, 12'hABC, 12'h123));
    check_val(32'({o_reference_halver, o_reference_doubler, o_ref_div_value}),
              32'({hd, code}));
    start = ref_pulses;
    mstart = mon_pulses;
    repeat (edges) begin
      @(negedge i_clk);
      i_ref_in = 1'b1;
      repeat (4) @(negedge i_clk);
      i_ref_in = 1'b0;
      repeat (3) @(negedge i_clk);
    end
    repeat (10) @(negedge i_clk);
    check_val(32'(ref_pulses - start), 32'(rises));
    check_val(32'(mon_pulses - mstart), 32'(rises));
  endtask

  task automatic scn_monitor();
    logic [3:0] mon_tab [7] = '{4'h0, 4'h1, 4'h4, 4'h4, 4'h5, 4'h3, 4'hF};
    logic ramp_tab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic pin_tab [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int f0;
    for (int i = 0; i < 7; i++) begin
      f0 = freq_pulses;
      host_u.send_word(div_word(ramp_tab[i], mon_tab[i], 12'h800 | 12'(i), 12'h123));
      check_val(32'({o_ramp_enable, o_monitor_select}),
                {27'h0, ramp_tab[i], mon_tab[i]});
      check_val(32'(o_whole_value), 32'h800 | 32'(i));
      check_val(32'(o_monitor_output_pin), 32'(pin_tab[i]));
      check_val(32'(freq_pulses - f0), 32'h1);
    end
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_ref_in = 1'b0;
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (10) @(negedge i_clk);
    check_reset();
    scn_raw_latches();
    scn_double_buffer();
    scn_ref_counter(5'h03, 2'h0, 9, 3);
    scn_monitor();
    scn_ref_counter(5'h00, 2'h0, 64, 2);
    scn_ref_counter(5'h02, 2'h3, 8, 4);
    complete_run();
  end
endmodule // tb
`default_nettype wire
